/* File: hdl/abi_alarm_blink_indicator.v */
// Functional notes
// - Fault drops output and cuts motor current.
// - Active fault blinks indicator red.
// - Blink count per group names cause.
// - Overheat at 85 C: two blinks.
// - Overvoltage: three blinks.
// - Overcurrent: five blinks.
// - Stored data corrupt: nine blinks.
// - Fault latched until power cycle.
`include "abi_consts.vh"

module abi_alarm_blink_indicator #(
  parameter TICK_CYCLES = `ABI_TICK_CYCLES,
  parameter ON_MS       = `ABI_BLINK_ON_MS,
  parameter OFF_MS      = `ABI_BLINK_OFF_MS,
  parameter GAP_MS      = `ABI_GROUP_GAP_MS
) (
  // Clock and power-up reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // Fault sensors, asynchronous to the clock
  input  wire [7:0] boardTempC,
  input  wire       overVoltage,
  input  wire       overCurrent,
  input  wire       dataCorrupt,
  input  wire       procFault,
  // Host and power stage
  output reg        fault_output,
  output reg        motorCurrentEn,
  // Power/fault indicator
  output reg        powerLedGreen,
  output reg        power_fault_indicator
);

  reg  [7:0]  tempMeta;
  reg  [7:0]  tempSync;
  reg  [3:0]  sensMeta;
  reg  [3:0]  sensSync;
  reg  [16:0] tickCount;
  reg         msTick;
  reg         faultLatched;
  reg  [3:0]  causeBlinks;
  wire        lampOn;
  wire [4:0]  trip;

  // Sensor levels cross two flops; a multi-bit temperature may be torn for
  // one sample, which the threshold compare can misjudge, and a false trip then stays latched.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tempMeta <= 8'h00;
      tempSync <= 8'h00;
      sensMeta <= 4'h0;
      sensSync <= 4'h0;
    end else begin
      tempMeta <= boardTempC;
      tempSync <= tempMeta;
      sensMeta <= {procFault, dataCorrupt, overCurrent, overVoltage};
      sensSync <= sensMeta;
    end
  end

  assign trip[0] = (tempSync >= `ABI_HEAT_LIMIT_C);
  assign trip[1] = sensSync[0];
  assign trip[2] = sensSync[1];
  assign trip[3] = sensSync[2];
  assign trip[4] = sensSync[3];

  // Millisecond enable for the blinker.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tickCount <= 17'h00000;
      msTick    <= 1'b0;
    end else if (tickCount == TICK_CYCLES[16:0] - 17'h00001) begin
      tickCount <= 17'h00000;
      msTick    <= 1'b1;
    end else begin
      tickCount <= tickCount + 17'h00001;
      msTick    <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      faultLatched <= 1'b0;
      causeBlinks  <= 4'h0;
    end else if (!faultLatched && (trip != 5'h00)) begin
      faultLatched <= 1'b1;
      if (trip[2])
        causeBlinks <= `ABI_BLINKS_CURR;
      else if (trip[1])
        causeBlinks <= `ABI_BLINKS_VOLT;
      else if (trip[0])
        causeBlinks <= `ABI_BLINKS_HEAT;
      else if (trip[3])
        causeBlinks <= `ABI_BLINKS_DATA;
      else
        causeBlinks <= `ABI_BLINKS_PROC;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      fault_output   <= 1'b0;
      motorCurrentEn <= 1'b0;
    end else begin
      fault_output   <= !faultLatched && (trip == 5'h00);
      motorCurrentEn <= !faultLatched && (trip == 5'h00);
    end
  end

  abi_blinker #(
    .ON_MS  (ON_MS),
    .OFF_MS (OFF_MS),
    .GAP_MS (GAP_MS)
  ) u_blinker (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .msTick     (msTick),
    .enable     (faultLatched),
    .blinkCount (causeBlinks),
    .lampOn     (lampOn)
  );

  always @(posedge core_clk) begin
    if (sys_rst) begin
      powerLedGreen         <= 1'b0;
      power_fault_indicator <= 1'b0;
    end else begin
      powerLedGreen         <= !faultLatched;
      power_fault_indicator <= faultLatched && lampOn;
    end
  end

endmodule

/* File: hdl/abi_consts.vh */
`ifndef ABI_CONSTS_VH
`define ABI_CONSTS_VH

// Blink counts that identify each fault cause.
`define ABI_BLINKS_HEAT      4'h2
`define ABI_BLINKS_VOLT      4'h3
`define ABI_BLINKS_CURR      4'h5
`define ABI_BLINKS_DATA      4'h9
`define ABI_BLINKS_PROC      4'h7

// Overheat threshold in degrees C, compared with the board temperature code.
`define ABI_HEAT_LIMIT_C     8'h55

// Blink timing in milliseconds and the clock rate in kHz.
`define ABI_CLK_KHZ          100000
`define ABI_BLINK_ON_MS      200
`define ABI_BLINK_OFF_MS     200
`define ABI_GROUP_GAP_MS     1500
`define ABI_TICK_CYCLES      (`ABI_CLK_KHZ)

// Blinker states.
`define ABI_ST_IDLE          2'h0
`define ABI_ST_ON            2'h1
`define ABI_ST_OFF           2'h2
`define ABI_ST_GAP           2'h3

`endif

/* File: hdl/abi_blinker.v */
`include "abi_consts.vh"

module abi_blinker #(
  parameter ON_MS  = `ABI_BLINK_ON_MS,
  parameter OFF_MS = `ABI_BLINK_OFF_MS,
  parameter GAP_MS = `ABI_GROUP_GAP_MS
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // Control
  input  wire       msTick,
  input  wire       enable,
  input  wire [3:0] blinkCount,
  // Lamp
  output reg        lampOn
);

  reg [1:0]  state;
  reg [10:0] msCount;
  reg [3:0]  blinkDone;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state     <= `ABI_ST_IDLE;
      msCount   <= 11'h000;
      blinkDone <= 4'h0;
      lampOn    <= 1'b0;
    end else if (!enable) begin
      state     <= `ABI_ST_IDLE;
      msCount   <= 11'h000;
      blinkDone <= 4'h0;
      lampOn    <= 1'b0;
    end else begin
      case (state)
        `ABI_ST_IDLE: begin
          state     <= `ABI_ST_ON;
          msCount   <= 11'h000;
          blinkDone <= 4'h0;
          lampOn    <= 1'b1;
        end
        `ABI_ST_ON: begin
          if (msTick) begin
            if (msCount == ON_MS[10:0] - 11'h001) begin
              msCount   <= 11'h000;
              lampOn    <= 1'b0;
              blinkDone <= blinkDone + 4'h1;
              if (blinkDone + 4'h1 >= blinkCount)
                state <= `ABI_ST_GAP;
              else
                state <= `ABI_ST_OFF;
            end else begin
              msCount <= msCount + 11'h001;
            end
          end
        end
        `ABI_ST_OFF: begin
          if (msTick) begin
            if (msCount == OFF_MS[10:0] - 11'h001) begin
              msCount <= 11'h000;
              lampOn  <= 1'b1;
              state   <= `ABI_ST_ON;
            end else begin
              msCount <= msCount + 11'h001;
            end
          end
        end
        `ABI_ST_GAP: begin
          if (msTick) begin
            if (msCount == GAP_MS[10:0] - 11'h001) begin
              msCount   <= 11'h000;
              blinkDone <= 4'h0;
              lampOn    <= 1'b1;
              state     <= `ABI_ST_ON;
            end else begin
              msCount <= msCount + 11'h001;
            end
          end
        end
        default: begin
          state  <= `ABI_ST_IDLE;
          lampOn <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: verification/abi_host_monitor.sv */
module abi_host_monitor (
  // Clock and power-up reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Watched line and verdict
  input  wire logic fault_output,
  output logic      hostRelapse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed;
  logic seenFault;
  // The first edge after power-up still shows the reset level, so it is skipped.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      armed <= 1'b0;
      seenFault <= 1'b0;
      hostRelapse <= 1'b0;
    end else begin
      armed <= 1'b1;
      seenFault <= seenFault | (armed & ~fault_output);
      hostRelapse <= hostRelapse | (seenFault & fault_output);
    end
  end
endmodule

/* File: verification/abi_alarm_properties.sv */
module abi_alarm_properties #(
  parameter int TICK_CYCLES = 4,
  parameter int ON_MS = 2,
  parameter int OFF_MS = 2,
  parameter int GAP_MS = 6
) (
  input wire logic core_clk, sys_rst,
  input wire logic [7:0] boardTempC,
  input wire logic overVoltage, overCurrent, dataCorrupt, procFault,
  input wire logic fault_output, motorCurrentEn, powerLedGreen, power_fault_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int darkRun;
  int litRun;
  always @(posedge core_clk) begin
    darkRun <= (sys_rst | fault_output | power_fault_indicator) ? 0 : darkRun + 1;
    litRun <= (sys_rst | ~power_fault_indicator) ? 0 : litRun + 1;
  end
  AST_CUT_TOGETHER: assert property (fault_output == motorCurrentEn)
    else $error("fault output and motor current disagree");
  AST_RED_ONLY_FAULT: assert property (power_fault_indicator |-> !fault_output && !powerLedGreen)
    else $error("red lamp lit without fault");
  AST_LIT_LEN: assert property (litRun <= ON_MS * TICK_CYCLES)
    else $error("blink lit too long");
  AST_HEAT: assert property ($rose(boardTempC >= 8'h55) |-> ##3 !fault_output)
    else $error("overheat not signalled");
  AST_VOLT: assert property ($rose(overVoltage) |-> ##3 !fault_output)
    else $error("overvoltage not signalled");
  AST_CURR: assert property ($rose(overCurrent) |-> ##3 !fault_output && !motorCurrentEn)
    else $error("overcurrent not signalled");
  AST_DATA: assert property ($rose(dataCorrupt) |-> ##3 !fault_output)
    else $error("data error not signalled");
  AST_LATCH: assert property (!fault_output && !$past(sys_rst) |=> !fault_output && !powerLedGreen)
    else $error("fault did not stay latched");
  AST_GAP: assert property (darkRun <= (GAP_MS + OFF_MS) * TICK_CYCLES + 2)
    else $error("blink groups stopped repeating");
endmodule

bind abi_alarm_blink_indicator abi_alarm_properties #(.TICK_CYCLES(TICK_CYCLES), .ON_MS(ON_MS),
  .OFF_MS(OFF_MS), .GAP_MS(GAP_MS)) props (.core_clk(core_clk), .sys_rst(sys_rst),
  .boardTempC(boardTempC), .overVoltage(overVoltage), .overCurrent(overCurrent),
  .dataCorrupt(dataCorrupt), .procFault(procFault), .fault_output(fault_output),
  .motorCurrentEn(motorCurrentEn), .powerLedGreen(powerLedGreen),
  .power_fault_indicator(power_fault_indicator));

/* File: verification/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] boardTempC = 8'h00;
  logic [3:0] sens = 4'h0;
  wire fault_output, motorCurrentEn, powerLedGreen, power_fault_indicator, hostRelapse;
  int failures = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  abi_alarm_blink_indicator #(.TICK_CYCLES(4), .ON_MS(2), .OFF_MS(2), .GAP_MS(6)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .boardTempC(boardTempC), .overVoltage(sens[3]),
    .overCurrent(sens[2]), .dataCorrupt(sens[1]), .procFault(sens[0]),
    .fault_output(fault_output), .motorCurrentEn(motorCurrentEn),
    .powerLedGreen(powerLedGreen), .power_fault_indicator(power_fault_indicator));
  abi_host_monitor host (.core_clk(core_clk), .sys_rst(sys_rst),
    .fault_output(fault_output), .hostRelapse(hostRelapse));
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic apply(logic [7:0] t, logic [3:0] s);
    @(posedge core_clk);
    boardTempC <= t;
    sens <= s;
  endtask
  task automatic power_up();
    sys_rst <= 1'b1;
    apply(8'h00, 4'h0);
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check("powerLedGreen up", powerLedGreen, 8'h01);
  endtask
  // A group ends at the first dark stretch clearly longer than the gap between blinks.
  task automatic count_group(output logic [7:0] n);
    logic prev;
    int dark;
    bit synced;
    n = 8'h00;
    dark = 0;
    synced = 0;
    prev = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      #1 dark = power_fault_indicator ? 0 : dark + 1;
      if (dark > 12 && n != 0) break;
      if (dark > 12) synced = 1;
      if (synced && power_fault_indicator && !prev) n++;
      prev = power_fault_indicator;
    end
  endtask
  task automatic expect_trip(logic [7:0] t, logic [3:0] s, logic [7:0] blinks);
    logic [7:0] n;
    power_up();
    apply(t, s);
    repeat (2) @(posedge core_clk);
    #1 check("fault_output early", fault_output, 8'h01);
    @(posedge core_clk);
    #1 check("fault_output", fault_output, 8'h00);
    check("motorCurrentEn", motorCurrentEn, 8'h00);
    count_group(n);
    check("powerLedGreen", powerLedGreen, 8'h00);
    check("blinks", n, blinks);
    apply(8'h00, 4'h4);
    count_group(n);
    check("latched blinks", n, blinks);
    check("hostRelapse", hostRelapse, 8'h00);
  endtask
  task automatic t_each_cause();
    expect_trip(8'h55, 4'h0, 8'h02);
    expect_trip(8'h00, 4'h8, 8'h03);
    expect_trip(8'h00, 4'h4, 8'h05);
    expect_trip(8'h00, 4'h2, 8'h09);
    expect_trip(8'h00, 4'h1, 8'h07);
    $display("t_each_cause done");
  endtask
  task automatic t_threshold_and_priority();
    power_up();
    apply(8'h54, 4'h0);
    repeat (40) @(posedge core_clk);
    #1 check("below limit", fault_output, 8'h01);
    expect_trip(8'h55, 4'hf, 8'h05);
    $display("t_threshold_and_priority done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    t_each_cause();
    t_threshold_and_priority();
    tally_and_finish();
  end
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule
